// File: tb_top.sv
// Self-checking bench for the supply monitor and overcurrent trip.
// Assumes the converter model beside the block and APB with one wait state.
`timescale 1ns/1ps
module tb_top;
  import vbm_pkg::*;
  localparam int unsigned TRIP = 20;
  logic        pclk, presetn, psel, penable, pwrite, bus_powered, reset_btn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, rerr, conv_start, conv_valid, irq;
  logic [4:0]  conv_sel;
  logic [11:0] conv_data, ex;
  logic [7:0]  port_power, port_data, short_mode, short_det;
  int          mismatches, n_checks, c0;

  vbm_top #(.TRIP_CYCLES(TRIP), .RESET_WINDOW(50)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_start(conv_start),
    .conv_sel(conv_sel), .conv_valid(conv_valid), .conv_data(conv_data),
    .bus_powered(bus_powered), .reset_btn(reset_btn), .short_det(short_det),
    .port_power(port_power), .port_data(port_data), .short_mode(short_mode), .irq(irq));
  vbm_conv_model u_model (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
    .conv_sel(conv_sel), .port_power(port_power), .conv_valid(conv_valid),
    .conv_data(conv_data));

  // The clock toggles every 25 ns, half of its 50 ns period.
  always #25 pclk = ~pclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt

  // Request is held until pready is sampled high; only the watchdog ends a hang.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // Reference filter step, written apart from the block's own filter.
  function automatic logic [11:0] ema(input logic [11:0] a, input logic [11:0] s);
    logic signed [13:0] r;
    r = $signed({2'b00, a}) + (($signed({2'b00, s}) - $signed({2'b00, a})) >>> 2);
    return (r < 0) ? 12'h000 : r[11:0];
  endfunction : ema

  task automatic t_reset();
    chk(port_power, 8'hFF);
    chk(port_data, 8'hFF);
    apb(1'b0, A_LIMIT, 32'h0);
    chk(rdat[11:0], LIMIT_DEFAULT);
    apb(1'b0, A_TOP, 32'h0);
    chk(rerr, 1'b1);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_trip();
    int n;
    apb(1'b1, A_LIMIT, 32'h100);
    apb(1'b1, A_LIMIT + 12'h004, 32'h100);
    apb(1'b1, A_PWR, 32'hFD);
    apb(1'b1, A_MASK, 32'h3);
    c0 = u_model.cnt[1];
    u_model.val[1] = 12'h200;
    u_model.val[3] = 12'h200;
    n = 0;
    while (irq !== 1'b1 && n < 60000) begin wt(1); n++; end
    chk(u_model.cnt[1], c0 + 1);
    chk(port_power[0], 1'b1);
    wt(TRIP + 5);
    chk(port_power[0], 1'b0);
    ex = 12'h000;
    for (int i = 0; i < c0; i++) ex = ema(ex, 12'h050);
    apb(1'b0, A_AVG + 12'h004, 32'h0);
    chk(rdat[11:0], ema(ex, 12'h200));
    $display("t_trip done");
  endtask : t_trip

  task automatic t_irq();
    apb(1'b1, A_MASK, 32'h0);
    wt(2);
    chk(irq, 1'b0);
    apb(1'b1, A_MASK, 32'h3);
    wt(2);
    chk(irq, 1'b1);
    apb(1'b1, A_STATUS, 32'h1);
    wt(2);
    chk(irq, 1'b0);
    chk(port_power[0], 1'b0);
    $display("t_irq done");
  endtask : t_irq

  task automatic t_seq();
    int n, c3;
    n = 0;
    while (conv_start !== 1'b1 && n < 4000) begin wt(1); n++; end
    n = 0;
    do begin wt(1); n++; end while (conv_start !== 1'b1 && n < 4000);
    chk(n, CONV_CYC);
    c3 = u_model.cnt[3];
    n = 0;
    while (u_model.cnt[3] == c3 && n < 60000) begin wt(1); n++; end
    wt(3);
    apb(1'b0, A_STATUS, 32'h0);
    chk(rdat[1:0], 2'b00);
    for (int s = 0; s < NUM_SIG; s++) chk(u_model.cnt[s] > 0, 1'b1);
    $display("t_seq done");
  endtask : t_seq

  task automatic t_pins();
    u_model.val[1] = 12'h050;
    u_model.val[3] = 12'h050;
    apb(1'b1, A_PWR, 32'hFF);
    wt(2);
    chk(port_power, 8'hFF);
    // Pins pass three flip-flops and one state stage: allow six edges.
    bus_powered <= 1'b1;
    short_det <= 8'h24;
    wt(6);
    chk(port_power, 8'h00);
    chk(short_mode, 8'h24);
    bus_powered <= 1'b0;
    short_det <= 8'h00;
    wt(6);
    chk(port_power, 8'hFF);
    chk(short_mode, 8'h00);
    apb(1'b1, A_LIMIT + 12'h008, 32'h321);
    apb(1'b1, A_CTRL, 32'h1);
    apb(1'b1, A_LIMIT + 12'h008, 32'h111);
    apb(1'b1, A_CTRL, 32'h2);
    apb(1'b0, A_LIMIT + 12'h008, 32'h0);
    chk(rdat[11:0], 12'h321);
    apb(1'b1, A_LIMIT, 32'h123);
    for (int i = 0; i < 2; i++) begin reset_btn <= 1'b1; wt(3); reset_btn <= 1'b0; wt(5); end
    wt(5);
    apb(1'b0, A_LIMIT, 32'h0);
    chk(rdat[11:0], LIMIT_DEFAULT);
    $display("t_pins done");
  endtask : t_pins

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  // Main sequence: reset for 12 cycles, then the scenarios in order.
  initial
  begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 12'h000;
    pwdata = 32'h0; bus_powered = 0; reset_btn = 0; mismatches = 0; n_checks = 0;
    short_det = 8'h00;
    for (int s = 0; s < NUM_SIG; s++) u_model.val[s] = s[0] ? 12'h050 : 12'h800;
    wt(12);
    presetn <= 1'b1;
    wt(2);
    t_reset();
    t_trip();
    t_irq();
    t_seq();
    t_pins();
    finish_test();
  end

  // Watchdog: a clean run needs about one and a quarter sweeps of conversions.
  initial
  begin
    #(80000 * 50);
    mismatches++;
    finish_test();
  end
endmodule : tb_top

// File: vbm_conv_model.sv
// Behavioural converter and power switches at the far side of the monitor.
// Assumes one start pulse per conversion and a table of values set by the bench.
`timescale 1ns/1ps
module vbm_conv_model
  import vbm_pkg::*;
(
  input  wire logic              pclk,       // System clock.
  input  wire logic              presetn,    // Async reset, active low.
  input  wire logic              conv_start, // Start pulse.
  input  wire logic [SIG_W-1:0]  conv_sel,   // Signal to convert.
  input  wire logic [7:0]        port_power, // Switch enables.
  output logic                   conv_valid, // Sample valid pulse.
  output logic      [MEAS_W-1:0] conv_data   // Sample value.
);
  logic [MEAS_W-1:0] val [NUM_SIG];
  int unsigned       cnt [NUM_SIG];
  logic [SIG_W-1:0]  sel_q;
  int unsigned       wait_q;
  logic              busy;
  logic [MEAS_W-1:0] smp;

  // A switched-off port shows no voltage; current reads the table so that
  // a back-fed port can still look loaded.
  always_comb
  begin
    smp = val[sel_q];
    if (!sel_q[0] && sel_q < SIG_VIN && !port_power[sel_q[3:1]])
      smp = 12'h000;
  end

  // Currents answer fast, voltages slow; data toggles while not valid so
  // that a stale value is never mistaken for a sample.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy       <= 1'b0;
      conv_valid <= 1'b0;
      conv_data  <= 12'h000;
      wait_q     <= 0;
      sel_q      <= 5'h00;
      cnt        <= '{default: 0};
    end
    else if (conv_start && !busy)
    begin
      busy       <= 1'b1;
      sel_q      <= conv_sel;
      wait_q     <= conv_sel[0] ? 3 : 40;
      conv_valid <= 1'b0;
      conv_data  <= ~conv_data;
    end
    else if (busy && wait_q == 0)
    begin
      busy         <= 1'b0;
      conv_valid   <= 1'b1;
      conv_data    <= smp;
      cnt[sel_q]   <= cnt[sel_q] + 1;
    end
    else
    begin
      wait_q     <= busy ? wait_q - 1 : 0;
      conv_valid <= 1'b0;
      conv_data  <= ~conv_data;
    end
  end
endmodule : vbm_conv_model

// File: vbm_ema.sv
// Divide-by-four exponential moving average step for one sample.
// Assumes unsigned 12-bit samples and outputs.
`timescale 1ns/1ps
module vbm_ema
  import vbm_pkg::*;
(
  input  wire logic [MEAS_W-1:0] sample,   // New raw sample.
  input  wire logic [MEAS_W-1:0] prev_avg, // Previous filtered output.
  output logic      [MEAS_W-1:0] new_avg   // Updated filtered output.
);
  logic signed [MEAS_W+1:0] diff;
  logic signed [MEAS_W+1:0] accum;
  logic signed [MEAS_W+1:0] sum;
  // Signed difference, shifted arithmetically, then clamped to range.
  always_comb
  begin
    diff    = $signed({2'b00, sample}) - $signed({2'b00, prev_avg}); // [RQ5]
    accum   = diff >>> EMA_SHIFT; // [RQ18]
    sum     = $signed({2'b00, prev_avg}) + accum; // [RQ5]
    new_avg = prev_avg;
    if (sum < 0)
      new_avg = '0; // [RQ18]
    else
      new_avg = sum[MEAS_W-1:0];
  end
endmodule : vbm_ema

// File: vbm_pkg.sv
// Package for the supply monitor and overcurrent trip block.
// Assumes a 20 MHz pclk and a 12-bit measurement converter.
package vbm_pkg;
  localparam int unsigned CLK_HZ        = 20000000;
  localparam int unsigned NUM_PORTS     = 8;
  localparam int unsigned NUM_SIG       = 17;
  localparam int unsigned SIG_W         = 5;
  localparam int unsigned MEAS_W        = 12;
  localparam int unsigned CONV_US       = 140;
  localparam int unsigned CONV_CYC      = (CONV_US * (CLK_HZ / 1000000));
  localparam int unsigned TRIP_US       = 1000;
  localparam int unsigned TRIP_CYC      = (TRIP_US * (CLK_HZ / 1000000));
  localparam int unsigned RESET_WIN_MS  = 5000;
  localparam int unsigned RESET_WIN_CYC = (RESET_WIN_MS * (CLK_HZ / 1000));
  localparam int unsigned CNT_W         = 27;
  localparam int unsigned EMA_SHIFT     = 2;
  localparam logic [11:0] LIMIT_DEFAULT = 12'hFFF;
  localparam logic [4:0]  SIG_VIN       = 5'h10;
  // Register byte addresses.
  localparam logic [11:0] A_CTRL   = 12'h000;
  localparam logic [11:0] A_STATUS = 12'h004;
  localparam logic [11:0] A_MASK   = 12'h008;
  localparam logic [11:0] A_PWR    = 12'h00C;
  localparam logic [11:0] A_DATA   = 12'h010;
  localparam logic [11:0] A_MODE   = 12'h014;
  localparam logic [11:0] A_ENUM   = 12'h018;
  localparam logic [11:0] A_LIMIT  = 12'h040;
  localparam logic [11:0] A_AVG    = 12'h080;
  localparam logic [11:0] A_TOP    = 12'h0C4;
  localparam int unsigned CTRL_SAVE = 0;
  localparam int unsigned CTRL_BOOT = 1;
endpackage : vbm_pkg

// File: vbm_top.sv
// Supply monitor: conversion sequencer, per-signal averages, current trip.
// Assumes a converter that answers each start with one sample per period,
// and power switches that obey the power enable outputs.
// Contract
// RQ1: Measure eight port voltages, currents, input voltage.
// RQ2: Interleave each port with two others.
// RQ3: Each sample gets one 140 us period.
// RQ4: Separate divide-by-four average per signal.
// RQ5: Subtract, quarter, add, store new output.
// RQ6: Then move to next signal, same procedure.
// RQ7: Settle 10 percent in 8, 1 percent 16.
// RQ8: Trip uses raw current samples only.
// RQ9: One sample above limit trips port.
// RQ10: Set flag, remove power after trip delay.
// RQ11: Trip delay typically one millisecond.
// RQ12: Tripped port stays off until software.
// RQ13: Software limits are 0 to 4095 mA.
// RQ14: Short-circuit mode lasts while short persists.
// RQ15: No port power when bus-powered upstream.
// RQ16: Double reset press restores defaults.
// RQ17: Saved configuration applies after save and reboot.
// RQ18: Arithmetic shift and clamp average.
// RQ19: Flag sticky; skip trip on unpowered ports.
`timescale 1ns/1ps
module vbm_top
  import vbm_pkg::*;
#(
  parameter int unsigned TRIP_CYCLES  = TRIP_CYC,     // Trip delay in cycles.
  parameter int unsigned RESET_WINDOW = RESET_WIN_CYC // Double press window.
)
(
  input  wire logic              pclk,        // System clock.
  input  wire logic              presetn,     // Async reset, active low.
  input  wire logic              psel,        // APB select.
  input  wire logic              penable,     // APB enable.
  input  wire logic              pwrite,      // APB direction.
  input  wire logic [11:0]       paddr,       // APB byte address.
  input  wire logic [31:0]       pwdata,      // APB write data.
  output logic      [31:0]       prdata,      // APB read data.
  output logic                   pready,      // APB ready.
  output logic                   pslverr,     // APB error.
  output logic                   conv_start,  // Converter start pulse.
  output logic      [SIG_W-1:0]  conv_sel,    // Signal being converted.
  input  wire logic              conv_valid,  // Sample valid pulse.
  input  wire logic [MEAS_W-1:0] conv_data,   // Sample value.
  input  wire logic              bus_powered, // Pin: system on upstream bus.
  input  wire logic              reset_btn,   // Pin: reset button.
  input  wire logic [7:0]        short_det,   // Pin: switch in short mode.
  output logic      [7:0]        port_power,  // Power switch enables.
  output logic      [7:0]        port_data,   // Data path enables.
  output logic      [7:0]        short_mode,  // Short-circuit status.
  output logic                   irq          // Level interrupt.
);
  typedef enum logic [1:0] {
    VBM_IDLE = 2'b00,
    VBM_CONV = 2'b01,
    VBM_WAIT = 2'b10
  } vbm_seq_t;

  typedef struct packed {
    vbm_seq_t             seq;
    logic [CNT_W-1:0]     tick;
    logic [SIG_W-1:0]     slot;
    logic [SIG_W-1:0]     conv_sel_q;
    logic [MEAS_W-1:0]    sample;
    logic [NUM_SIG-1:0][MEAS_W-1:0] avg;
    logic [NUM_PORTS-1:0][MEAS_W-1:0] limit;
    logic [NUM_PORTS-1:0][MEAS_W-1:0] saved_limit;
    logic [NUM_PORTS-1:0][CNT_W-1:0]  trip_cnt;
    logic [7:0]           pending;
    logic [7:0]           pwr;
    logic [7:0]           data;
    logic [7:0]           mode;
    logic [7:0]           saved_pwr;
    logic [7:0]           saved_data;
    logic [7:0]           saved_mode;
    logic [15:0]          enum_dly;
    logic [15:0]          saved_enum;
    logic [7:0]           status;
    logic [7:0]           mask;
    logic [2:0]           bus_sync;
    logic                 bus_pw;
    logic [2:0]           btn_sync;
    logic                 btn;
    logic                 btn_armed;
    logic [CNT_W-1:0]     btn_cnt;
    logic [7:0][2:0]      sc_sync;
    logic [7:0]           sc;
    logic                 started;
    logic                 start_q;
    logic [31:0]          rdata;
    logic                 ready;
    logic                 err;
    logic                 irq;
  } vbm_state_t;

  vbm_state_t r;
  vbm_state_t next_r;
  logic [MEAS_W-1:0] ema_out;

  // Sequence table: each port's voltage and current sit apart, two other
  // measurements in between, so one slot order serves all ports.
  function automatic logic [SIG_W-1:0] seq_sig(input logic [SIG_W-1:0] s);
    logic [SIG_W-1:0] grp;
    grp = s / 5'h6;
    // The last two ports share their group with the input supply, so that
    // every one of the seventeen signals still gets exactly one slot.
    if (s == 5'h0E)
      seq_sig = SIG_VIN;
    else if (s >= 5'h0F)
      seq_sig = 5'((s - 5'h0F) * 5'h2 + 5'h0D); // [RQ1] [RQ2]
    else if (s >= 5'h0C)
      seq_sig = 5'((s - 5'h0C) * 5'h2 + 5'h0C); // [RQ2]
    else if (s % 5'h6 < 5'h3)
      seq_sig = 5'((grp * 5'h3 + s % 5'h6) * 5'h2); // [RQ2]
    else
      seq_sig = 5'((grp * 5'h3 + s % 5'h6 - 5'h3) * 5'h2 + 5'h1);
  endfunction : seq_sig

  // A word is mapped if it falls in any register window.
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a < A_TOP) && (a[1:0] == 2'b00) &&
                !((a > A_ENUM) && (a < A_LIMIT)) &&
                !((a >= A_LIMIT + 12'h020) && (a < A_AVG));
  endfunction : is_mapped

  vbm_ema u_ema (
    .sample   (r.sample),
    .prev_avg (r.avg[r.conv_sel_q]),
    .new_avg  (ema_out)
  );
  logic [SIG_W-1:0] cur_sig;
  assign cur_sig = seq_sig(r.slot);

  // All next-state logic in one place.
  always_comb
  begin
    logic [2:0] pi;
    logic       sig_is_cur;
    next_r = r;
    pi = 3'h0;
    sig_is_cur = 1'b0;
    next_r.start_q = 1'b0;
    next_r.ready = 1'b0;
    next_r.err = 1'b0;
    // Three-stage pin synchronisers; a change counts when stages agree.
    next_r.bus_sync = {r.bus_sync[1:0], bus_powered};
    if (r.bus_sync[2] == r.bus_sync[1])
      next_r.bus_pw = r.bus_sync[2];
    next_r.btn_sync = {r.btn_sync[1:0], reset_btn};
    if (r.btn_sync[2] == r.btn_sync[1])
      next_r.btn = r.btn_sync[2];
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      next_r.sc_sync[p] = {r.sc_sync[p][1:0], short_det[p]};
      if (r.sc_sync[p][2] == r.sc_sync[p][1])
        next_r.sc[p] = r.sc_sync[p][2]; // [RQ14]
    end
    // Conversion sequencer: one fixed period per sample.
    case (r.seq)
      VBM_IDLE:
      begin
        next_r.seq = VBM_CONV;
        next_r.tick = '0;
        next_r.start_q = 1'b1;
      end
      VBM_CONV:
      begin
        next_r.tick = r.tick + 1'b1;
        if (conv_valid)
        begin
          next_r.sample = conv_data;
          next_r.seq = VBM_WAIT;
        end
        if (r.tick >= CNT_W'(CONV_CYC - 1))
          next_r.seq = VBM_WAIT; // [RQ3]
      end
      VBM_WAIT:
      begin
        next_r.tick = r.tick + 1'b1;
        if (r.tick >= CNT_W'(CONV_CYC - 1))
        begin
          next_r.avg[cur_sig] = ema_out; // [RQ4] [RQ5] [RQ7]
          next_r.tick = '0;
          next_r.slot = (r.slot == SIG_W'(NUM_SIG - 1)) ? '0 : r.slot + 1'b1; // [RQ1] [RQ6]
          next_r.seq = VBM_CONV;
          next_r.start_q = 1'b1;
          pi = cur_sig[3:1];
          sig_is_cur = cur_sig[0] && (cur_sig != SIG_VIN);
          // Raw sample compare; unpowered ports are skipped.
          if (sig_is_cur && r.pwr[pi] && !r.pending[pi] && (r.sample > r.limit[pi]))
          begin
            next_r.pending[pi] = 1'b1; // [RQ8] [RQ9] [RQ19]
            next_r.trip_cnt[pi] = '0;
          end
        end
      end
      default:
        next_r.seq = VBM_IDLE;
    endcase
    next_r.conv_sel_q = seq_sig(next_r.slot); // [RQ6]
    // Trip delay, then the switch is opened and stays open.
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      if (r.pending[p])
      begin
        next_r.trip_cnt[p] = r.trip_cnt[p] + 1'b1;
        if (r.trip_cnt[p] >= CNT_W'(TRIP_CYCLES - 1))
        begin
          next_r.pending[p] = 1'b0;
          next_r.pwr[p] = 1'b0; // [RQ10] [RQ11] [RQ12]
        end
      end
    end
    // APB slave, answers in the access cycle's following edge.
    if (psel && penable)
    begin
      if (!r.ready)
      begin
        next_r.ready = 1'b1;
        next_r.err = !is_mapped(paddr);
        next_r.rdata = '0;
      end
      if (pwrite && is_mapped(paddr) && r.ready)
      begin
        if (paddr == A_CTRL)
        begin
          if (pwdata[CTRL_SAVE])
          begin
            next_r.saved_limit = r.limit; // [RQ17]
            next_r.saved_pwr = r.pwr;
            next_r.saved_data = r.data;
            next_r.saved_mode = r.mode;
            next_r.saved_enum = r.enum_dly;
          end
          if (pwdata[CTRL_BOOT])
          begin
            next_r.limit = r.saved_limit;
            next_r.pwr = r.saved_pwr;
            next_r.data = r.saved_data;
            next_r.mode = r.saved_mode;
            next_r.enum_dly = r.saved_enum;
          end
        end
        else if (paddr == A_STATUS)
          next_r.status = r.status & ~pwdata[7:0];
        else if (paddr == A_MASK)
          next_r.mask = pwdata[7:0];
        else if (paddr == A_PWR)
        begin
          next_r.pwr = pwdata[7:0]; // [RQ12]
          next_r.pending = r.pending & pwdata[7:0];
          next_r.status = r.status & ~(pwdata[7:0] & ~r.pwr); // [RQ19]
        end
        else if (paddr == A_DATA)
          next_r.data = pwdata[7:0];
        else if (paddr == A_MODE)
          next_r.mode = pwdata[7:0];
        else if (paddr == A_ENUM)
          next_r.enum_dly = pwdata[15:0];
        else if (paddr >= A_LIMIT && paddr < A_LIMIT + 12'h020)
          next_r.limit[paddr[4:2]] = pwdata[MEAS_W-1:0]; // [RQ13]
      end
      else if (!pwrite && is_mapped(paddr) && !r.ready)
      begin
        if (paddr == A_STATUS)
          next_r.rdata = {24'h0, r.status};
        else if (paddr == A_MASK)
          next_r.rdata = {24'h0, r.mask};
        else if (paddr == A_PWR)
          next_r.rdata = {24'h0, r.pwr};
        else if (paddr == A_DATA)
          next_r.rdata = {24'h0, r.data};
        else if (paddr == A_MODE)
          next_r.rdata = {24'h0, r.mode};
        else if (paddr == A_ENUM)
          next_r.rdata = {16'h0, r.enum_dly};
        else if (paddr >= A_LIMIT && paddr < A_AVG)
          next_r.rdata = {20'h0, r.limit[paddr[4:2]]};
        else if (paddr >= A_AVG)
          next_r.rdata = {20'h0, r.avg[5'((paddr - A_AVG) >> 2)]};
      end
    end
    // Overcurrent flags: a new trip wins over a software clear.
    for (int p = 0; p < NUM_PORTS; p++)
      if (r.pending[p] && r.trip_cnt[p] == '0)
        next_r.status[p] = 1'b1; // [RQ10] [RQ19]
    // Double press of the reset button within the window restores defaults.
    if (r.btn_armed)
    begin
      next_r.btn_cnt = r.btn_cnt + 1'b1;
      if (r.btn_cnt >= CNT_W'(RESET_WINDOW - 1))
        next_r.btn_armed = 1'b0;
    end
    if (next_r.btn && !r.btn)
    begin
      if (r.btn_armed)
      begin
        next_r.btn_armed = 1'b0;
        next_r.pwr = 8'hFF; // [RQ16]
        next_r.data = 8'hFF;
        next_r.mode = 8'hFF;
        next_r.enum_dly = 16'h0000;
        next_r.pending = 8'h00;
        for (int p = 0; p < NUM_PORTS; p++)
          next_r.limit[p] = LIMIT_DEFAULT;
      end
      else
      begin
        next_r.btn_armed = 1'b1;
        next_r.btn_cnt = '0;
      end
    end
    next_r.irq = |(next_r.status & next_r.mask);
  end

  // One register stage for the whole state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.seq <= VBM_IDLE;
      r.pwr <= 8'hFF;
      r.data <= 8'hFF;
      r.mode <= 8'hFF;
      r.saved_pwr <= 8'hFF;
      r.saved_data <= 8'hFF;
      r.saved_mode <= 8'hFF;
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        r.limit[p] <= LIMIT_DEFAULT;
        r.saved_limit[p] <= LIMIT_DEFAULT;
      end
    end
    else
      r <= next_r;
  end

  // Bus power gates the switches; the enable itself is not lost.
  logic [7:0] pwr_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwr_q <= 8'h00;
    else
      pwr_q <= next_r.bus_pw ? 8'h00 : next_r.pwr; // [RQ15]
  end

  assign prdata     = r.rdata;
  assign pready     = r.ready;
  assign pslverr    = r.err;
  assign conv_start = r.start_q;
  assign conv_sel   = r.conv_sel_q;
  assign port_power = pwr_q;
  assign port_data  = r.data;
  assign short_mode = r.sc;
  assign irq        = r.irq;

  trip_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ10]
    $rose(r.pending[0]) |=> r.status[0]) else $error("Trip flag not set.");
  bus_off_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ15]
    r.bus_pw |-> port_power == 8'h00) else $error("Power on while bus powered.");
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("Ready held longer than one cycle.");
  start_tick_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ3]
    r.seq == VBM_WAIT && r.tick == CNT_W'(CONV_CYC - 1) |=> conv_start && r.tick == '0)
    else $error("Conversion period not closed by a start.");
  slot_step_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ6]
    r.seq == VBM_WAIT && r.tick == CNT_W'(CONV_CYC - 1) |=> r.slot != $past(r.slot))
    else $error("Sequence did not move to the next signal.");
  power_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [RQ12]
    !r.pwr[0] && !(psel && penable && pwrite) && !r.btn_armed |=> !r.pwr[0])
    else $error("Tripped port powered without software.");
endmodule : vbm_top
